/* File: src/lcm_cell.sv */
// Configurable logic cell with APB configuration and status
// Summary of operation
// - Normal mode: four-input lookup, carry-in or input three selectable as one input.
// - Normal mode: lookup output may be ANDed with cascade-in to form cascade-out.
// - Local and global outputs each independently select register or lookup.
// - Packed: input four feeds register, lookup computes separate three-input function.
// - Packed register still obeys clock enable, clear and preset.
// - Arithmetic: two three-input lookups give sum and carry-out; cascade still usable.
// - Up/down counter: counter enable, clock enable, direction and load controls.
// - Counters: lookups give next count and fast carry; two-input mux loads data.
// - Counter register also loads asynchronously via clear and preset, no lookup used.
// - Clearable counter: synchronous clear replaces direction, taken from cascade input.
// - Clearable counter: load mux output ANDed with synchronous clear.
// - Emulated tri-state bus: contention reads low, no driver reads high.
// - Clear and preset are active low; unused ones held high.
// - Six asynchronous control modes: clear, preset, both, load+clear, load+preset, load.
// - First group control in load modes loads input three into the register.
// - Chip-wide reset overrides all controls; inverted registers end up preset.
// - Clear-only: either group control clears, preset inactive.
// - Preset-only: first control loads a tied-high input three.
// - Clear-and-preset: first control presets, second control clears.
// - Load-with-clear: first control loads via preset and clear, second only clears.
// - Load-with-preset: inverted storage; second control presets, first loads.
// - Clock enable in every mode; input one may serve as the enable.
//
// The register offsets and the APB interface to the registers were decided locally.
`timescale 1ns/1ns
`include "lcm_defines.svh"

module lcm_cell #(
  parameter int TRI_WIDTH = 4,
  parameter int ADDR_W = 12
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic cell_input_one,
  input wire logic cell_input_two,
  input wire logic cell_input_three,
  input wire logic cell_input_four,
  input wire logic carry_in,
  input wire logic cascade_in,
  input wire logic group_control_first,
  input wire logic group_control_second,
  input wire logic chip_reset_n,
  output logic local_out,
  output logic global_out,
  output logic carry_out,
  output logic cascade_out,
  output lcm_pkg::lcm_op_t cell_mode
);
  import lcm_pkg::*;

  // ==========================================================
  // Elaboration checks
  generate
    // Enables and data share one register, so the data field bounds the width
    if (TRI_WIDTH < 1 || TRI_WIDTH > `LCM_TRI_DAT) begin : g_bad_tri
      $error("TRI_WIDTH must be 1 to 8");
    end
    if (`LCM_TRI_DAT + TRI_WIDTH > `LCM_TRI_W) begin : g_bad_tri_field
      $error("TRI_WIDTH overflows the bus register");
    end
    if (ADDR_W < `LCM_OFF_W) begin : g_bad_addr
      $error("ADDR_W must be at least 12");
    end
  endgenerate

  // ==========================================================
  // Pin synchronisers
  localparam int NSYNC = 9;
  logic [NSYNC-1:0] pin_raw;
  logic [NSYNC-1:0] sync1_reg;
  logic [NSYNC-1:0] sync2_reg;

  assign pin_raw = {chip_reset_n, group_control_second, group_control_first,
                    cascade_in, carry_in, cell_input_four, cell_input_three,
                    cell_input_two, cell_input_one};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_reg <= `LCM_SYNC_RST;
      sync2_reg <= `LCM_SYNC_RST;
    end else begin
      sync1_reg <= pin_raw;
      sync2_reg <= sync1_reg;
    end
  end

  logic i1, i2, i3, i4, ci, cs, c1, c2, crn;
  // Only the second stage is read; the first may still be metastable
  assign {crn, c2, c1, cs, ci, i4, i3, i2, i1} = sync2_reg;

  // ==========================================================
  // Configuration state
  logic [`LCM_CFG_W-1:0] cfg_reg;
  logic [`LCM_LUT_W-1:0] lut_reg;
  logic [`LCM_TRI_W-1:0] tri_reg;
  lcm_op_t op;
  lcm_am_t am;
  logic csel, pack, lsel, gsel, casc_en, crst_en, cen_sel;

  assign op = lcm_op_t'(cfg_reg[`LCM_CFG_OP]);
  assign am = lcm_am_t'(cfg_reg[`LCM_CFG_AM]);
  assign csel = cfg_reg[`LCM_CFG_CSEL];
  assign pack = cfg_reg[`LCM_CFG_PACK];
  assign lsel = cfg_reg[`LCM_CFG_LSEL];
  assign gsel = cfg_reg[`LCM_CFG_GSEL];
  assign casc_en = cfg_reg[`LCM_CFG_CASC];
  assign crst_en = cfg_reg[`LCM_CFG_CRST];
  assign cen_sel = cfg_reg[`LCM_CFG_CEN];
  assign cell_mode = op;

  // ==========================================================
  // Lookup paths
  logic stor_reg;
  logic inv;
  logic q;
  logic lut_c;
  logic dir;
  logic [2:0] cidx;

  assign inv = (am == LCM_AM_LDPRE);
  assign q = stor_reg ^ inv;
  assign lut_c = csel ? ci : i3;
  // Up-only clearable counter has no direction bit
  assign dir = (op == LCM_OP_UPDN) ? cs : 1'b0;
  assign cidx = {ci & i4, dir, q};

  logic lut_o;
  logic cout;
  logic casc_o;
  logic dnext;
  logic ld_mux;

  always_comb begin
    lut_o = 1'b0;
    cout = 1'b0;
    dnext = 1'b0;
    ld_mux = 1'b0;
    casc_o = 1'b0;
    case (op)
      LCM_OP_NORMAL: begin
        if (pack) begin
          lut_o = lut_reg[{1'b0, lut_c, i2, i1}];
        end else begin
          lut_o = lut_reg[{i4, lut_c, i2, i1}];
        end
        casc_o = casc_en ? (lut_o & cs) : lut_o;
        dnext = pack ? i4 : casc_o;
      end
      LCM_OP_ARITH: begin
        lut_o = lut_reg[{1'b0, ci, i2, i1}];
        cout = lut_reg[{1'b1, ci, i2, i1}];
        casc_o = casc_en ? (lut_o & cs) : lut_o;
        dnext = casc_o;
      end
      LCM_OP_UPDN: begin
        lut_o = lut_reg[{1'b0, cidx}];
        cout = lut_reg[{1'b1, cidx}];
        ld_mux = i3 ? i2 : lut_o;
        casc_o = lut_o;
        dnext = ld_mux;
      end
      LCM_OP_CLRCNT: begin
        lut_o = lut_reg[{1'b0, cidx}];
        cout = lut_reg[{1'b1, cidx}];
        ld_mux = i3 ? i2 : lut_o;
        casc_o = lut_o;
        // Clear is active low at the AND gate
        dnext = ld_mux & cs;
      end
      default: begin
        lut_o = 1'b0;
      end
    endcase
  end

  // ==========================================================
  // Clear and preset control
  logic clr_n;
  logic pre_n;
  logic ld;
  logic crst;

  // Load data is inverted to match inverted storage
  assign ld = inv ? ~i3 : i3;
  // Chip reset is opt-in so an unused pin cannot wipe the cell
  assign crst = crst_en & ~crn;

  always_comb begin
    clr_n = 1'b1;
    pre_n = 1'b1;
    case (am)
      LCM_AM_CLR: begin
        clr_n = ~(c1 | c2);
      end
      LCM_AM_PRE: begin
        pre_n = ~c1;
      end
      LCM_AM_CLRPRE: begin
        pre_n = ~c1;
        clr_n = ~c2;
      end
      LCM_AM_LDCLR, LCM_AM_LDPRE: begin
        pre_n = ~(c1 & ld);
        clr_n = ~((c1 & ~ld) | c2);
      end
      LCM_AM_LOAD: begin
        pre_n = ~(c1 & ld);
        clr_n = ~(c1 & ~ld);
      end
      default: begin
        clr_n = 1'b1;
        pre_n = 1'b1;
      end
    endcase
  end

  // ==========================================================
  // Cell register
  logic ce;
  assign ce = cen_sel ? i1 : 1'b1;

  // Controls act from synchronised lines, so "asynchronous" load lags the pins
  // Clear beats preset, which the load modes rely on
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stor_reg <= 1'b0;
    end else if (crst) begin
      stor_reg <= 1'b0;
    end else if (!clr_n) begin
      stor_reg <= 1'b0;
    end else if (!pre_n) begin
      stor_reg <= 1'b1;
    end else if (ce) begin
      stor_reg <= dnext ^ inv;
    end
  end

  // ==========================================================
  // Cell outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      local_out <= 1'b0;
      global_out <= 1'b0;
    end else begin
      local_out <= lsel ? q : lut_o;
      global_out <= gsel ? q : lut_o;
    end
  end

  // Chains are registered too, so with the two sync stages a long chain costs three cycles per cell
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      carry_out <= 1'b0;
      cascade_out <= 1'b0;
    end else begin
      carry_out <= cout;
      cascade_out <= casc_o;
    end
  end

  // ==========================================================
  // Tri-state emulation
  logic [TRI_WIDTH-1:0] tri_en;
  logic [TRI_WIDTH-1:0] tri_dat;
  logic tri_bus;

  assign tri_en = tri_reg[TRI_WIDTH-1:0];
  assign tri_dat = tri_reg[`LCM_TRI_DAT +: TRI_WIDTH];

  // Contention resolves low instead of to an unknown mix
  always_comb begin
    if (tri_en == '0) begin
      tri_bus = 1'b1;
    end else if (!$onehot(tri_en)) begin
      tri_bus = 1'b0;
    end else begin
      tri_bus = |(tri_en & tri_dat);
    end
  end

  // ==========================================================
  // APB slave
  logic setup;
  logic acc;
  logic [`LCM_OFF_W-1:0] off;
  logic wr_en;
  logic hit;
  logic bad;
  logic [31:0] rd_mux;

  assign setup = psel & ~penable;
  assign acc = psel & penable & pready;
  assign off = paddr[`LCM_OFF_W-1:0];
  assign hit = (off == `LCM_OFF_CFG) || (off == `LCM_OFF_LUT) ||
               (off == `LCM_OFF_STAT) || (off == `LCM_OFF_TRI);
  // Status is read only; writing it is an error
  assign bad = ~hit | (pwrite & (off == `LCM_OFF_STAT)) |
               (ADDR_W > `LCM_OFF_W && (paddr >> `LCM_OFF_W) != '0);
  // Errored writes leave every register untouched
  assign wr_en = acc & pwrite & ~pslverr;

  // Status is a live view, seen through the pin synchronisers
  always_comb begin
    rd_mux = `LCM_RD_RST;
    case (off)
      `LCM_OFF_CFG: rd_mux[`LCM_CFG_W-1:0] = cfg_reg;
      `LCM_OFF_LUT: rd_mux[`LCM_LUT_W-1:0] = lut_reg;
      `LCM_OFF_TRI: rd_mux[`LCM_TRI_W-1:0] = tri_reg;
      `LCM_OFF_STAT: begin
        rd_mux[`LCM_STAT_Q] = q;
        rd_mux[`LCM_STAT_LUT] = lut_o;
        rd_mux[`LCM_STAT_COUT] = cout;
        rd_mux[`LCM_STAT_CASC] = casc_o;
        rd_mux[`LCM_STAT_LOC] = local_out;
        rd_mux[`LCM_STAT_GLB] = global_out;
        rd_mux[`LCM_STAT_TRI] = tri_bus;
      end
      default: rd_mux = `LCM_RD_RST;
    endcase
  end

  // One wait-free access phase: answer is prepared during setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= setup;
      pslverr <= setup & bad;
    end
  end

  // Read data holds until the next setup, for masters that sample late
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= `LCM_RD_RST;
    end else if (setup) begin
      prdata <= (!pwrite && !bad) ? rd_mux : `LCM_RD_RST;
    end
  end

  // ==========================================================
  // Register writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_reg <= `LCM_CFG_RST;
    end else if (wr_en && off == `LCM_OFF_CFG) begin
      cfg_reg <= pwdata[`LCM_CFG_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lut_reg <= `LCM_LUT_RST;
    end else if (wr_en && off == `LCM_OFF_LUT) begin
      lut_reg <= pwdata[`LCM_LUT_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tri_reg <= `LCM_TRI_RST;
    end else if (wr_en && off == `LCM_OFF_TRI) begin
      tri_reg <= pwdata[`LCM_TRI_W-1:0];
    end
  end

endmodule : lcm_cell

/* File: src/lcm_defines.svh */
// Register map, field positions and reset values of the logic cell
`ifndef LCM_DEFINES_SVH
`define LCM_DEFINES_SVH
// ==========================================================
// Register offsets
`define LCM_OFF_CFG 12'h000
`define LCM_OFF_LUT 12'h004
`define LCM_OFF_STAT 12'h008
`define LCM_OFF_TRI 12'h00c
`define LCM_OFF_W 12
// ==========================================================
// Configuration fields
`define LCM_CFG_W 12
`define LCM_CFG_OP 1:0
`define LCM_CFG_AM 4:2
`define LCM_CFG_CSEL 5
`define LCM_CFG_PACK 6
`define LCM_CFG_LSEL 7
`define LCM_CFG_GSEL 8
`define LCM_CFG_CASC 9
`define LCM_CFG_CRST 10
`define LCM_CFG_CEN 11
// ==========================================================
// Lookup table and tri-state fields
`define LCM_LUT_W 16
`define LCM_TRI_W 16
`define LCM_TRI_DAT 8
// ==========================================================
// Status fields
`define LCM_STAT_Q 0
`define LCM_STAT_LUT 1
`define LCM_STAT_COUT 2
`define LCM_STAT_CASC 3
`define LCM_STAT_LOC 4
`define LCM_STAT_GLB 5
`define LCM_STAT_TRI 6
// ==========================================================
// Reset values
`define LCM_CFG_RST 12'h000
`define LCM_LUT_RST 16'h0000
`define LCM_TRI_RST 16'h0000
`define LCM_SYNC_RST 9'h100
`define LCM_RD_RST 32'h0000_0000
`endif

/* File: src/lcm_pkg.sv */
// Mode types of the logic cell
package lcm_pkg;
  // ==========================================================
  // Operating modes
  typedef enum logic [1:0] {
    LCM_OP_NORMAL = 2'h0,
    LCM_OP_ARITH = 2'h1,
    LCM_OP_UPDN = 2'h2,
    LCM_OP_CLRCNT = 2'h3
  } lcm_op_t;
  // ==========================================================
  // Asynchronous clear and preset modes
  typedef enum logic [2:0] {
    LCM_AM_CLR = 3'h0,
    LCM_AM_PRE = 3'h1,
    LCM_AM_CLRPRE = 3'h2,
    LCM_AM_LDCLR = 3'h3,
    LCM_AM_LDPRE = 3'h4,
    LCM_AM_LOAD = 3'h5
  } lcm_am_t;
endpackage : lcm_pkg

/* File: bench/lcm_cell_asserts.sv */
// Port level checks of the logic cell
`timescale 1ns/1ns
`include "lcm_defines.svh"
module lcm_cell_asserts import lcm_pkg::*; #(
  parameter int ADDR_W = 12
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic carry_out,
  input wire lcm_pkg::lcm_op_t cell_mode
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ==========================================================
  // Bus handshake
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_wr_cfg;
    psel && penable && pready && pwrite && !pslverr && paddr == `LCM_OFF_CFG;
  endsequence
  chk_setup_ready: assert property (s_setup |=> pready) else $error("no ready after setup");
  chk_ready_pulse: assert property (pready |=> !pready) else $error("ready held too long");
  chk_ready_access: assert property (pready |-> psel && penable) else $error("ready outside access");
  chk_err_zero: assert property (pslverr |-> pready && prdata == 0) else $error("error with data");
  chk_write_zero: assert property (pready && pwrite |-> prdata == 0) else $error("write gave data");
  chk_ro_write: assert property (psel && penable && pwrite && paddr == `LCM_OFF_STAT |-> pslverr)
    else $error("status write accepted");
  // ==========================================================
  // Mode register
  chk_mode_write: assert property (s_wr_cfg |=> cell_mode == $past(pwdata[1:0])) else $error("mode not taken");
  chk_mode_stable: assert property (!(psel && penable && pwrite) |=> $stable(cell_mode))
    else $error("mode moved");
  chk_normal_carry: assert property (cell_mode == LCM_OP_NORMAL [*2] |-> carry_out == 0)
    else $error("carry in normal mode");
endmodule : lcm_cell_asserts
bind lcm_cell lcm_cell_asserts #(.ADDR_W(ADDR_W)) lcm_cell_asserts_inst (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .carry_out(carry_out), .cell_mode(cell_mode));

/* File: bench/lcm_partner.sv */
// Neighbouring cell driving the carry and cascade chains
`timescale 1ns/1ns
module lcm_partner (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [1:0] chain_v,
  output logic carry_in,
  output logic cascade_in
);
  // Registered like a real neighbour, never combinational
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      carry_in <= 1'b0;
      cascade_in <= 1'b0;
    end else begin
      carry_in <= chain_v[0];
      cascade_in <= chain_v[1];
    end
  end
endmodule : lcm_partner

/* File: bench/lcm_cell_bench.sv */
// Self-checking bench of the logic cell
`timescale 1ns/1ns
`include "lcm_defines.svh"
module lcm_cell_bench;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e, lo, go, co, cso, ci, cs, q0, ex;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r, c, t, lf;
  logic [15:0] L;
  logic [6:0] pin, p;
  logic [3:0] x;
  logic [1:0] ch;
  lcm_pkg::lcm_op_t mode;
  int num_errors, check_count;
  // ==========================================================
  // Design and far side
  lcm_cell lcm_cell_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cell_input_one(pin[0]), .cell_input_two(pin[1]), .cell_input_three(pin[2]), .cell_input_four(pin[3]),
    .carry_in(ci), .cascade_in(cs), .group_control_first(pin[4]), .group_control_second(pin[5]),
    .chip_reset_n(pin[6]), .local_out(lo), .global_out(go), .carry_out(co), .cascade_out(cso), .cell_mode(mode));
  lcm_partner lcm_partner_inst (.pclk(pclk), .presetn(presetn), .chain_v(ch), .carry_in(ci), .cascade_in(cs));
  always #10 pclk = ~pclk;
  // ==========================================================
  // Helpers
  function automatic logic [31:0] rnd();
    lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
    return lf;
  endfunction : rnd
  // Both lines together only where the outcome is defined
  function automatic logic aexp(int am, int k, logic d3, logic q);
    case (am)
      0: return 1'b0;
      1: return (k & 1) ? 1'b1 : q;
      2: return k == 1;
      3: return (k == 1) ? d3 : 1'b0;
      4: return (k == 1) ? d3 : 1'b1;
      default: return (k & 1) ? d3 : q;
    endcase
  endfunction : aexp
  task automatic chk(input logic [31:0] s, input logic [31:0] xp, input string n);
    check_count++;
    if (s !== xp) begin
      num_errors++;
      $display("mismatch %s exp %h seen %h", n, xp, s);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Pins pass two sync flops, so settle before reading status
  task automatic st();
    repeat (6) @(posedge pclk);
    apb(1'b0, `LCM_OFF_STAT, 32'h0);
  endtask : st
  task automatic pins(input logic [6:0] v, input logic [1:0] cv);
    @(posedge pclk);
    pin <= v;
    ch <= cv;
  endtask : pins
  task automatic test_done();
    if (num_errors == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : test_done
  initial begin
    #400000;
    num_errors++;
    test_done();
  end
  // ==========================================================
  // Scenarios
  initial begin
    {pclk, presetn, psel, penable, pwrite, paddr, pwdata, ch} = '0;
    pin = 7'h40;
    lf = 32'h45a6;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      apb(1'b0, (i == 2) ? `LCM_OFF_TRI : 12'(4 * i), 32'h0);
      chk(r, 32'h0, "reset value");
    end
    st();
    chk(r[6], 1'b1, "idle bus");
    apb(1'b1, `LCM_OFF_STAT, 32'hffff_ffff);
    chk(e, 1'b1, "ro write");
    apb(1'b0, 12'h010, 32'h0);
    chk(e, 1'b1, "unmapped error");
    chk(r, 32'h0, "unmapped data");
    for (int op = 0; op < 4; op++) begin
      apb(1'b1, `LCM_OFF_CFG, op);
      @(posedge pclk);
      chk(mode, op, "mode");
    end
    for (int i = 0; i < 12; i++) begin
      L = 16'(rnd());
      c = (i < 8) ? rnd() & 32'h3e0 : 32'h1;
      apb(1'b1, `LCM_OFF_LUT, {16'h0, L});
      apb(1'b1, `LCM_OFF_CFG, c);
      p = 7'(rnd() & 32'h0f) | 7'h40;
      pins(p, 2'(rnd()));
      st();
      x = {c[0] | (!c[6] & p[3]), c[5] & !c[0] ? ch[0] : (c[0] ? ch[0] : p[2]), p[1], p[0]};
      if (c[0]) chk({r[2], co}, {2{L[x]}}, "arith carry");
      if (!c[0]) chk(r[1], L[x], "lut");
      if (!c[0]) chk(r[3], c[9] ? L[x] & ch[1] : L[x], "cascade");
      if (!c[0]) chk(cso, c[9] ? L[x] & ch[1] : L[x], "cascade out");
      if (c[0]) chk({r[1], cso}, {2{L[{1'b0, x[2:0]}]}}, "arith sum");
      if (c[6]) chk(r[0], p[3], "packed q");
      if (!c[0] && (c[6] || !c[7])) chk(lo, c[7] ? p[3] : L[x], "local");
      if (!c[0] && (c[6] || !c[8])) chk(go, c[8] ? p[3] : L[x], "global");
    end
    for (int op = 2; op < 4; op++) for (int i = 0; i < 4; i++) begin
      L = 16'(rnd());
      apb(1'b1, `LCM_OFF_LUT, {16'h0, L});
      apb(1'b1, `LCM_OFF_CFG, 32'h800 | op);
      p = 7'(rnd() & 32'h0e) | 7'h40;
      pins(p, 2'(rnd()));
      st();
      q0 = r[0];
      x = {1'b1, ch[0] & p[3], (op == 2) & ch[1], q0};
      chk(r[2], L[x], "count carry");
      chk(co, L[x], "count carry out");
      @(posedge pclk);
      pin[0] <= 1'b1;
      @(posedge pclk);
      pin[0] <= 1'b0;
      x[3] = 1'b0;
      repeat (2) begin
        st();
        chk(r[0], (p[2] ? p[1] : L[x]) & (op == 2 || ch[1]), "count");
      end
    end
    for (int am = 0; am < 6; am++) for (int k = 1; k < 4; k++) if (!(am == 4 && k == 3)) begin
      apb(1'b1, `LCM_OFF_CFG, 32'hc40 | (am << 2));
      p = 7'(rnd() & 32'h04) | 7'h40;
      pins(p, 2'b00);
      st();
      q0 = r[0];
      ex = aexp(am, k, p[2], q0);
      pins(p | 7'(k << 4), 2'b00);
      st();
      chk(r[0], ex, "async");
      pins(p, 2'b00);
      st();
      chk(r[0], ex, "hold");
      pins((p & 7'h3f) | 7'h10, 2'b00);
      st();
      chk(r[0], am == 4, "chip reset");
      pins(p, 2'b00);
    end
    for (int i = 0; i < 8; i++) begin
      t = rnd() & 32'h0f0f;
      apb(1'b1, `LCM_OFF_TRI, t);
      st();
      chk(r[6], t[3:0] == 0 ? 1 : ($countones(t[3:0]) > 1 ? 0 : |(t[11:8] & t[3:0])), "bus");
    end
    test_done();
  end
endmodule : lcm_cell_bench
